// ==== logic/pmc_consts.svh ====
// Constants for the power management control block
//
// Summary of operation
// - Control register readable in every power state
// - Writes ignored until one read after reset/wake
// - Power state field bits 13-12, resets 00b
// - Byte test write wakes reduced power device
// - Transceiver reset bit holds reset 100us, self-clears
// - Writes to reset bit ignored while set
// - Wake frame event drives enabled wake output
// - Wake frame event raises wake interrupt when enabled and unmasked
// - Energy event drives enabled wake output
// - Energy event raises wake interrupt when enabled and unmasked
// - Bit 6 selects open-drain or push-pull
// - Open-drain output always active low
// - Bit 0 ready flag, read only
// - Pulse select gives 50ms pulse, else level
// - Push-pull polarity bit: set high, clear low
// - Output enable gates pin, not interrupt
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// ============================================================
// Register offsets
`define PMC_OFS_BYTE_TEST   8'h64
`define PMC_OFS_CTRL        8'h84
`define PMC_OFS_IRQ_STATUS  8'h90
`define PMC_OFS_IRQ_MASK    8'h94

// ============================================================
// Control field positions
`define PMC_BIT_READY       0
`define PMC_BIT_OUT_EN      1
`define PMC_BIT_POL         2
`define PMC_BIT_PULSE       3
`define PMC_BIT_TYPE        6
`define PMC_BIT_ENERGY_EVENT_ENABLE       8
`define PMC_BIT_WF_EN       9
`define PMC_BIT_XRST        10
`define PMC_STATE_LO        12
`define PMC_STATE_HI        13

// ============================================================
// Reset values and timing
`define PMC_STATE_RESET     2'h0
`define PMC_CLK_HZ          25000000
`define PMC_XRST_US         100
`define PMC_XRST_CYC        ((`PMC_XRST_US * (`PMC_CLK_HZ / 1000000)))
`define PMC_PULSE_MS        50
`define PMC_PULSE_CYC       ((`PMC_PULSE_MS * (`PMC_CLK_HZ / 1000)))
`define PMC_WAKE_CYC        16

`endif

// ==== logic/pmc_pkg.sv ====
// Types for the power management control block
package pmc_pkg;
   typedef enum logic [1:0] {
      PMC_FULL_POWER_STATE,
      PMC_WAKE_FRAME_SLEEP_STATE,
      PMC_ENERGY_DETECT_SLEEP_STATE,
      PMC_RESERVED_STATE
   } pmc_power_state_t;

   typedef enum logic [1:0] {
      PMC_RUN,
      PMC_SLEEP,
      PMC_WAKING
   } pmc_seq_t;

   typedef struct packed {
      logic       wake_frame_event_enable;
      logic       energy_event_enable;
      logic       wake_output_drive_type;
      logic       wake_output_pulse_select;
      logic       wake_output_polarity;
      logic       wake_output_enable;
   } pmc_cfg_t;

   typedef struct packed {
      pmc_power_state_t power_state_select;
      pmc_seq_t         seq;
      logic [4:0]       wake_cnt;
      logic             ready;
      logic             read_seen;
      pmc_cfg_t         cfg;
      logic             transceiver_reset_request;
      logic [11:0]      xrst_cnt;
      logic [20:0]      pulse_cnt;
      logic             wake_active;
      logic [1:0]       irq_status;
      logic [1:0]       irq_mask;
      logic [1:0]       wf_sync;
      logic [1:0]       ed_sync;
      logic             pready;
      logic [31:0]      prdata;
      logic             pslverr;
      logic             wake_out;
      logic             wake_oe;
      logic             xrst_out;
      logic             irq;
   } pmc_state_t;
endpackage

// ==== logic/pmc_power_management_control.sv ====
// Power management control register, wake output and transceiver reset timer
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "pmc_consts.svh"

module pmc_power_management_control #(
   parameter int unsigned PULSE_CYC = `PMC_PULSE_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Wake event inputs from the detectors (asynchronous)
   input  wire logic        wake_frame_event,
   input  wire logic        energy_event,
   // Wake output pin, value and drive enable
   output logic             wake_output_o,
   output logic             wake_output_oe,
   // Transceiver reset, active high
   output logic             transceiver_reset,
   // Wake interrupt, active high level
   output logic             wake_interrupt,
   // Current power state for the rest of the chip
   output logic [1:0]       power_state_select
);

   pmc_pkg::pmc_state_t s_q;
   pmc_pkg::pmc_state_t s_d;

   // ============================================================
   // Overview
   // All state in one packed word; one process builds the next
   // value, one flop bank stores it, every output is a register bit.
   //
   // Bus: request taken in its first access cycle, answered one
   // cycle later; the answer stands for one cycle. Unmapped
   // addresses answer with an error, never with a stall.
   //
   // Write lock: after reset and after each wake the writable words
   // refuse writes until the host has read once with ready set.
   // Refused writes still complete, so a host that breaks the rule
   // sees no error, only no effect.
   //
   // Sleep: a non-zero power state drops ready. Only a byte test
   // write ends sleep; the settle count runs out before ready rises.
   //
   // Transceiver reset: a one in the request bit starts a fixed
   // hold; the bit reads one until the hold ends and then clears.
   //
   // Interrupt: sticky status per source, write one to clear, and
   // a mask of the same layout in front of the level output.
   //
   // Wake pin: open drain pulls low while active and floats
   // otherwise; push-pull always drives and follows the polarity bit.
   //
   // Limitation: the reserved power code is not blocked here; a host
   // that writes it parks the block asleep until a byte test write.

   // ============================================================
   // Helper functions
   // Read view of the control word; unused bits read zero
   // Bits 11 and 7 stay zero, as do all bits above 13
   function automatic logic [31:0] ctrl_word(input pmc_pkg::pmc_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`PMC_STATE_HI:`PMC_STATE_LO] = s.power_state_select;
      w[`PMC_BIT_XRST]   = s.transceiver_reset_request;
      w[`PMC_BIT_WF_EN]  = s.cfg.wake_frame_event_enable;
      w[`PMC_BIT_ENERGY_EVENT_ENABLE]  = s.cfg.energy_event_enable;
      w[`PMC_BIT_TYPE]   = s.cfg.wake_output_drive_type;
      w[`PMC_BIT_PULSE]  = s.cfg.wake_output_pulse_select;
      w[`PMC_BIT_POL]    = s.cfg.wake_output_polarity;
      w[`PMC_BIT_OUT_EN] = s.cfg.wake_output_enable;
      w[`PMC_BIT_READY]  = s.ready;
      return w;
   endfunction

   // Address in the map, used for the error answer
   function automatic logic mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         `PMC_OFS_CTRL:       hit = 1'b1;
         `PMC_OFS_BYTE_TEST:  hit = 1'b1;
         `PMC_OFS_IRQ_STATUS: hit = 1'b1;
         `PMC_OFS_IRQ_MASK:   hit = 1'b1;
         default:             hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Write strobe for one writable word
   // One home for the lock rule, shared by all three words
   function automatic logic reg_wr(input logic ok, input logic rdy,
                                   input logic [7:0] a, input logic [7:0] ofs);
      return ok && rdy && (a == ofs);
   endfunction

   // ============================================================
   // Next state
   always_comb begin
      logic       acc;
      logic       wr_ok;
      logic [1:0] ev;
      logic       trig;
      logic       active_lvl;
      // Defaults first, so no path leaves a latch
      acc        = 1'b0;
      wr_ok      = 1'b0;
      ev         = 2'h0;
      trig       = 1'b0;
      active_lvl = 1'b0;
      s_d        = s_q;

      // Event inputs come from another domain: two stages first
      // Only the second stage is read below; the first may be unsettled
      s_d.wf_sync = {s_q.wf_sync[0], wake_frame_event};
      s_d.ed_sync = {s_q.ed_sync[0], energy_event};

      // Single access phase answer, after one wait state
      // The registered answer costs one wait state but keeps the
      // read mux off the output path
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      // Taken on the first access cycle; the answer blocks a second take
      acc = psel && penable && !s_q.pready;
      // Writes only count once a read has been seen, and only when ready except byte test
      wr_ok = acc && pwrite && s_q.read_seen;
      if (acc) begin
         s_d.pready  = 1'b1;
         s_d.pslverr = !mapped(paddr);
         s_d.prdata  = 32'h0000_0000;
         if (!pwrite) begin
            s_d.read_seen = 1'b1;
            // Byte test reads zero; it is only a wake strobe
            case (paddr)
               `PMC_OFS_CTRL:       s_d.prdata = ctrl_word(s_q);
               `PMC_OFS_IRQ_STATUS: s_d.prdata = {30'h0, s_q.irq_status};
               `PMC_OFS_IRQ_MASK:   s_d.prdata = {30'h0, s_q.irq_mask};
               default:             s_d.prdata = 32'h0000_0000;
            endcase
         end
      end

      // Control and irq writes, accepted only while fully awake
      // Event enables and pin style change together, in one write
      if (reg_wr(wr_ok, s_q.ready, paddr, `PMC_OFS_CTRL)) begin
         s_d.cfg.wake_frame_event_enable  = pwdata[`PMC_BIT_WF_EN];
         s_d.cfg.energy_event_enable      = pwdata[`PMC_BIT_ENERGY_EVENT_ENABLE];
         s_d.cfg.wake_output_drive_type   = pwdata[`PMC_BIT_TYPE];
         s_d.cfg.wake_output_pulse_select = pwdata[`PMC_BIT_PULSE];
         s_d.cfg.wake_output_polarity     = pwdata[`PMC_BIT_POL];
         s_d.cfg.wake_output_enable       = pwdata[`PMC_BIT_OUT_EN];
         if (!s_q.transceiver_reset_request && pwdata[`PMC_BIT_XRST]) begin
            s_d.transceiver_reset_request = 1'b1;
            s_d.xrst_cnt = 12'h000;
         end
         // Writing 00b keeps the state; only a wake returns it to 00b
         // Reserved code 11b is left to the host; entering sleep drops ready
         if (pwdata[`PMC_STATE_HI:`PMC_STATE_LO] != 2'h0) begin
            s_d.power_state_select =
               pmc_pkg::pmc_power_state_t'(pwdata[`PMC_STATE_HI:`PMC_STATE_LO]);
            s_d.seq       = pmc_pkg::PMC_SLEEP;
            s_d.ready     = 1'b0;
            s_d.read_seen = 1'b0;
         end
      end

      // Mask write; the mask gates the interrupt line only
      if (reg_wr(wr_ok, s_q.ready, paddr, `PMC_OFS_IRQ_MASK)) begin
         s_d.irq_mask = pwdata[1:0];
      end

      // Transceiver reset hold; counter sized for the 100us figure
      // The bit reads one for the whole hold, so a repeated request
      // is refused above and cannot stretch or restart the hold
      if (s_q.transceiver_reset_request) begin
         if (s_q.xrst_cnt == 12'(`PMC_XRST_CYC - 1)) begin
            s_d.transceiver_reset_request = 1'b0;
         end else begin
            s_d.xrst_cnt = s_q.xrst_cnt + 12'h001;
         end
      end

      // Wake events: bit 0 energy, bit 1 wake frame
      // A disabled source neither sets status nor moves the pin
      ev[0] = s_q.ed_sync[1] && s_q.cfg.energy_event_enable;
      ev[1] = s_q.wf_sync[1] && s_q.cfg.wake_frame_event_enable;
      trig  = |ev;

      // Sequencer: sleep until byte test write, then settle, then ready
      // Wake events do not end sleep by themselves; the host must
      // answer the wake signal with the byte test write
      case (s_q.seq)
         pmc_pkg::PMC_RUN: begin
            // Awake: nothing to do until the host asks for sleep
            s_d.ready = s_d.ready;
         end
         pmc_pkg::PMC_SLEEP: begin
            // Any write to byte test wakes, read seen or not
            if (acc && pwrite && paddr == `PMC_OFS_BYTE_TEST) begin
               s_d.seq      = pmc_pkg::PMC_WAKING;
               s_d.wake_cnt = 5'h00;
               s_d.power_state_select = pmc_pkg::PMC_FULL_POWER_STATE;
            end
         end
         pmc_pkg::PMC_WAKING: begin
            // Fixed settle count before ready
            if (s_q.wake_cnt == 5'(`PMC_WAKE_CYC - 1)) begin
               s_d.seq   = pmc_pkg::PMC_RUN;
               s_d.ready = 1'b1;
               // Lock again at ready rise: one more read needed
               s_d.read_seen = 1'b0;
            end else begin
               s_d.wake_cnt = s_q.wake_cnt + 5'h01;
            end
         end
         default: begin
            // Unused code: fall back to awake
            s_d.seq = pmc_pkg::PMC_RUN;
         end
      endcase

      // Sticky status: event set wins over write-one clear
      // A clear that meets a new event leaves the bit set, so no
      // event is lost between read and clear
      if (reg_wr(wr_ok, s_q.ready, paddr, `PMC_OFS_IRQ_STATUS)) begin
         s_d.irq_status = s_q.irq_status & ~pwdata[1:0];
      end
      // Set after the clear, so the set wins
      s_d.irq_status = s_d.irq_status | ev;

      // Wake indication: level while status set, or one timed pulse
      // Pulse mode ignores the status bits; a still-present event
      // starts the next pulse straight away
      if (trig && !s_q.wake_active) begin
         s_d.wake_active = 1'b1;
         s_d.pulse_cnt   = 21'h000000;
      end else if (s_q.wake_active) begin
         if (s_q.cfg.wake_output_pulse_select) begin
            if (s_q.pulse_cnt == 21'(PULSE_CYC - 1)) begin
               s_d.wake_active = trig;
               s_d.pulse_cnt   = 21'h000000;
            end else begin
               s_d.pulse_cnt = s_q.pulse_cnt + 21'h000001;
            end
         end else begin
            s_d.wake_active = |s_d.irq_status;
         end
      end
      // Clearing both enables drops the pin at once
      if (!s_q.cfg.wake_frame_event_enable && !s_q.cfg.energy_event_enable) begin
         s_d.wake_active = 1'b0;
      end

      // Pin drive: open drain pulls low only; push-pull follows polarity
      // Open drain never drives high, so wired-OR peers are safe
      active_lvl = s_q.wake_active && s_q.cfg.wake_output_enable;
      if (!s_q.cfg.wake_output_drive_type) begin
         s_d.wake_out = 1'b0;
         s_d.wake_oe  = active_lvl;
      end else begin
         s_d.wake_oe  = 1'b1;
         s_d.wake_out = s_q.cfg.wake_output_polarity ? active_lvl : !active_lvl;
      end


      // Pin copies taken from the next value, so they move with the state
      s_d.xrst_out = s_d.transceiver_reset_request;
      s_d.irq      = |(s_d.irq_status & s_d.irq_mask);
   end

   // ============================================================
   // State register
   // Reset leaves the sequencer settling, so ready rises on its own
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q                    <= '0;
         s_q.power_state_select <= pmc_pkg::pmc_power_state_t'(`PMC_STATE_RESET);
         s_q.seq                <= pmc_pkg::PMC_WAKING;
      end else begin
         s_q <= s_d;
      end
   end

   // ============================================================
   // Outputs straight from the state register
   // No logic between flop and port, so pin timing is known
   assign pready             = s_q.pready;
   assign prdata             = s_q.prdata;
   assign pslverr            = s_q.pslverr;
   assign wake_output_o      = s_q.wake_out;
   assign wake_output_oe     = s_q.wake_oe;
   assign transceiver_reset  = s_q.xrst_out;
   assign wake_interrupt     = s_q.irq;
   assign power_state_select = s_q.power_state_select;

endmodule

// ==== sim/pmc_host_model.sv ====
// Host processor model driving the APB register port
`timescale 1ns/1ps

module pmc_host_model (
   // Clock
   input  wire logic        pclk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   logic [31:0] rdata;
   logic        err;

   // ============================================================
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // One transfer; request held until pready seen high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; the bench watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ==== sim/pmc_power_management_control_sva.sv ====
// Assertion checker for the power management control block
`timescale 1ns/1ps
`include "pmc_consts.svh"

module pmc_power_management_control_sva #(
   parameter int unsigned PULSE_CYC = 20
) (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // Outputs
   input wire logic        transceiver_reset,
   input wire logic [1:0]  power_state_select
);
   logic [11:0] hold_q;

   // All checks run on the bus clock and pause in reset
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ============================================================
   // Cycles the transceiver reset has stayed high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 12'h000;
      end else begin
         hold_q <= transceiver_reset ? hold_q + 12'h001 : 12'h000;
      end
   end

   sequence s_take;
      psel && penable && !pready;
   endsequence
   sequence s_wake_wr;
      s_take ##0 (pwrite && paddr == `PMC_OFS_BYTE_TEST && power_state_select != 2'h0);
   endsequence

   a_answer_next: assert property (s_take |=> pready) else $error("no answer");
   a_answer_once: assert property (pready |=> !pready) else $error("long answer");
   a_error_with_ready: assert property (pslverr |-> pready) else $error("stray error");
   a_hold_min: assert property ($fell(transceiver_reset) |-> hold_q >= 12'h9c4)
      else $error("reset hold short");
   a_hold_max: assert property (transceiver_reset |-> hold_q < 12'ha28)
      else $error("reset hold long");
   a_state_legal: assert property (power_state_select != 2'h3) else $error("bad state");
   a_wake_state: assert property (s_wake_wr |-> ##[1:40] power_state_select == 2'h0)
      else $error("no wake");
   a_sleep_cause: assert property (($changed(power_state_select) && power_state_select != 2'h0)
      |-> $past(psel && penable && pwrite && paddr == `PMC_OFS_CTRL))
      else $error("state moved alone");
endmodule

bind pmc_power_management_control pmc_power_management_control_sva #(.PULSE_CYC(PULSE_CYC))
   u_pmc_power_management_control_sva (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pready(pready), .pslverr(pslverr),
      .transceiver_reset(transceiver_reset), .power_state_select(power_state_select));

// ==== sim/pmc_power_management_control_tb.sv ====
// Self-checking testbench for the power management control block
`timescale 1ns/1ps
`include "pmc_consts.svh"

module pmc_power_management_control_tb;
   localparam int unsigned PC = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        wake_frame_event, energy_event, wake_output_o, wake_output_oe;
   logic        transceiver_reset, wake_interrupt;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, cfg;
   logic [1:0]  power_state_select;
   int          bad_count, n_compared, seed, i, n;

   pmc_power_management_control #(.PULSE_CYC(PC)) u_pmc_power_management_control (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .wake_frame_event(wake_frame_event), .energy_event(energy_event),
      .wake_output_o(wake_output_o), .wake_output_oe(wake_output_oe),
      .transceiver_reset(transceiver_reset), .wake_interrupt(wake_interrupt),
      .power_state_select(power_state_select));
   pmc_host_model u_pmc_host_model (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

   // ============================================================
   // Clock, 40 ns period
   initial pclk = 1'b0;
   always #20 pclk = ~pclk;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task give_verdict;
      if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      u_pmc_host_model.xfer(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      u_pmc_host_model.xfer(1'b0, a, 32'h0);
   endtask

   // Expected {oe, o}: open drain only pulls low while active
   function logic [31:0] pin_exp(input logic pp, input logic pol, input logic act);
      return pp ? {30'h0, 1'b1, act ~^ pol} : {30'h0, act, 1'b0};
   endfunction

   // Poll until ready; early reads do not unlock writes
   task wait_ready;
      n = 0;
      do begin
         rd(`PMC_OFS_CTRL);
         n++;
      end while (u_pmc_host_model.rdata[0] !== 1'b1 && n < 40);
   endtask

   // Short event, long enough for the two-flop synchroniser
   task fire(input logic wf);
      @(posedge pclk);
      wake_frame_event <= wf;
      energy_event <= !wf;
      repeat (4) @(posedge pclk);
      wake_frame_event <= 1'b0;
      energy_event <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask

   // Watchdog
   initial begin
      #(60000 * 40);
      bad_count++;
      give_verdict;
   end

   // ============================================================
   // Main sequence
   initial begin
      seed = 19814;
      bad_count = 0;
      n_compared = 0;
      presetn = 1'b0;
      wake_frame_event = 1'b0;
      energy_event = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      wr(`PMC_OFS_CTRL, 32'h100); // write before any read is dropped
      rd(`PMC_OFS_CTRL);
      chk(u_pmc_host_model.rdata, 32'h1);
      rd(8'h20);
      chk(32'(u_pmc_host_model.err), 32'h1);
      wr(`PMC_OFS_IRQ_MASK, 32'h3);
      // Open drain with polarity set, energy event
      wr(`PMC_OFS_CTRL, 32'h106);
      fire(1'b0);
      chk(32'(wake_interrupt), 32'h1);
      chk({30'h0, wake_output_oe, wake_output_o}, pin_exp(1'b0, 1'b1, 1'b1));
      rd(`PMC_OFS_IRQ_STATUS);
      chk(u_pmc_host_model.rdata, 32'h1);
      wr(`PMC_OFS_IRQ_STATUS, 32'h1);
      repeat (3) @(posedge pclk);
      chk({29'h0, wake_output_oe, wake_output_o, wake_interrupt}, 32'h0);
      // Push-pull, wake frame events, every pulse and polarity pair
      for (i = 0; i < 4; i++) begin
         cfg = 32'h240 | ((32'(i) & 32'h3) << 2) | ($random(seed) & 32'h2);
         wr(`PMC_OFS_CTRL, cfg);
         fire(1'b1);
         chk(32'(wake_interrupt), 32'h1);
         chk({30'h0, wake_output_oe, wake_output_o}, pin_exp(1'b1, cfg[2], cfg[1]));
         repeat (30) @(posedge pclk);
         chk({30'h0, wake_output_oe, wake_output_o},
             pin_exp(1'b1, cfg[2], cfg[1] & !cfg[3]));
         wr(`PMC_OFS_IRQ_STATUS, 32'h2);
         repeat (3) @(posedge pclk);
         chk({30'h0, wake_output_o, wake_interrupt}, {30'h0, !cfg[2], 1'b0});
      end
      // Transceiver reset, second request while set must not restart it
      wr(`PMC_OFS_CTRL, 32'h400);
      repeat (1000) @(posedge pclk);
      rd(`PMC_OFS_CTRL);
      chk(32'(u_pmc_host_model.rdata[10]), 32'h1);
      wr(`PMC_OFS_CTRL, 32'h400);
      n = 0;
      while (transceiver_reset === 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n >= 1400 && n < 1500), 32'h1);
      rd(`PMC_OFS_CTRL);
      chk(32'(u_pmc_host_model.rdata[10]), 32'h0);
      // Both sleep states, woken by the byte test write
      for (i = 1; i < 3; i++) begin
         wr(`PMC_OFS_CTRL, 32'(i) << 12);
         repeat (2) @(posedge pclk);
         chk(32'(power_state_select), 32'(i));
         rd(`PMC_OFS_CTRL);
         chk(u_pmc_host_model.rdata & 32'h3001, 32'(i) << 12);
         wr(`PMC_OFS_BYTE_TEST, $random(seed));
         wait_ready;
         chk(32'(u_pmc_host_model.rdata[0]), 32'h1);
         chk(32'(power_state_select), 32'h0);
      end
      give_verdict;
   end
endmodule
